/* File: design/sdcd_decoder.v */
/*
 command decoder of a ddr sdram: samples pins each rising edge, emits one
 registered command and its fields, tracks bursts, power-down and self refresh.
 assumes all pins arrive from outside through two-flop synchronisers here;
 clock enable low freezes all state.
*/
// How it works
// - sample select, activate, three command pins and cke every edge
// - activate high makes pins commands; low makes them row bits 16..14
// - mode set is all three low; bank bits pick register, address data
// - activate low with select low opens a row; all pins carry row
// - high-low pins read or write; we picks; bit 10 precharges, 12 low chops
// - refresh, precharge, reserved, zq long/short and nop by pin code
// - cke edges give self refresh or power-down entry and exit; des
// - bursts run to their end, never cut by later commands
// - fixed or per-command burst length follows the mode register value set while no burst runs
// - termination input never affects decoding; off in self refresh
// - no refresh activity while in power-down
// - field widths set by density; top bits optional
// - deselect blocks new commands; running work continues
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_defs.vh"

module sdcd_decoder #(
   parameter BG_W   = `SDCD_BG_W,
   parameter BA_W   = `SDCD_BA_W,
   parameter ADDR_W = `SDCD_ADDR_W
) (
   input  wire                   mclk,
   input  wire                   rst_n,
   input  wire                   clk_en,
   input  wire                   cke,
   input  wire                   cs_n,
   input  wire                   act_n,
   input  wire                   ras_n_a16,
   input  wire                   cas_n_a15,
   input  wire                   we_n_a14,
   input  wire [BG_W-1:0]        bg,
   input  wire [BA_W-1:0]        ba,
   input  wire [ADDR_W-1:0]      addr,
   input  wire                   odt,
   output reg  [`SDCD_CMD_W-1:0] cmd_ff,
   output reg                    cmd_vld_ff,
   output reg  [BG_W-1:0]        bg_out_ff,
   output reg  [BA_W-1:0]        ba_out_ff,
   output reg  [ADDR_W-1:0]      addr_out_ff,
   output reg                    auto_pre_ff,
   output reg                    four_beat_chop_ff,
   output reg                    burst_busy_ff,
   output reg                    odt_en_ff,
   output reg                    refresh_ok_ff,
   output reg  [`SDCD_MODE_W-1:0] mode_ff
);

   // ----------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------
   localparam SYN_W = 6 + BG_W + BA_W + ADDR_W;

   reg  [SYN_W-1:0] sync1_ff;
   reg  [SYN_W-1:0] sync2_ff;
   reg              cke_prev_ff;
   reg  [1:0]       bl_mode_ff;
   reg  [3:0]       beat_cnt_ff;

   wire             s_cke;
   wire             s_cs_n;
   wire             s_act_n;
   wire             s_ras;
   wire             s_cas;
   wire             s_we;
   wire             s_odt;
   wire [BG_W-1:0]  s_bg;
   wire [BA_W-1:0]  s_ba;
   wire [ADDR_W-1:0] s_addr;

   always @(posedge mclk) begin
      if (!rst_n) begin
         sync1_ff <= {SYN_W{1'b0}};
         sync2_ff <= {SYN_W{1'b0}};
      end else if (clk_en) begin
         sync1_ff <= {cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr};
         sync2_ff <= sync1_ff;
      end
   end

   assign {s_cke, s_cs_n, s_act_n, s_ras, s_cas, s_we, s_bg, s_ba, s_addr} = sync2_ff;

   // odt synchronised on its own, never part of command decode
   reg odt1_ff;
   reg odt2_ff;
   always @(posedge mclk) begin
      if (!rst_n) begin
         odt1_ff <= 1'b0;
         odt2_ff <= 1'b0;
      end else if (clk_en) begin
         odt1_ff <= odt;
         odt2_ff <= odt1_ff;
      end
   end
   assign s_odt = odt2_ff;

   // ----------------------------------------------------------------------
   // power states (one-hot) and helpers
   // ----------------------------------------------------------------------
   localparam [`SDCD_MODE_W-1:0] ST_IDLE = `SDCD_MODE_IDLE;
   localparam [`SDCD_MODE_W-1:0] ST_SR   = `SDCD_MODE_SR;
   localparam [`SDCD_MODE_W-1:0] ST_PD   = `SDCD_MODE_PD;

   // either column command; both start a burst
   function is_rw;
      input [`SDCD_CMD_W-1:0] c;
      begin
         is_rw = (c == `SDCD_CMD_WR) || (c == `SDCD_CMD_RD);
      end
   endfunction

   // chop from the stored burst setting and the a12 pin
   function chop_sel;
      input [1:0] bl_mode;
      input       a12;
      begin
         chop_sel = (bl_mode == `SDCD_BL_FIX4) ||
                    ((bl_mode == `SDCD_BL_PERCMD) && !a12);
      end
   endfunction

   // burst length in clock cycles, two beats per cycle
   function [3:0] burst_cycles;
      input chop;
      begin
         burst_cycles = chop ? `SDCD_BEATS4 : `SDCD_BEATS8;
      end
   endfunction

   // mode set aimed at the register holding the burst setting
   function mr0_write;
      input [`SDCD_CMD_W-1:0] c;
      input                   bg0;
      input [BA_W-1:0]        bank;
      begin
         mr0_write = (c == `SDCD_CMD_MRS) && ({bg0, bank} == `SDCD_MR0_SEL);
      end
   endfunction

   // ----------------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------------
   reg [`SDCD_CMD_W-1:0] nxt_cmd;
   reg [ADDR_W-1:0]      nxt_addr;

   always @* begin
      nxt_addr = s_addr;
      nxt_cmd  = `SDCD_CMD_ILL;
      if (!s_act_n)
         nxt_addr[16:14] = {s_ras, s_cas, s_we};
      case ({cke_prev_ff, s_cke})
         2'b11: begin
            if (s_cs_n)
               nxt_cmd = `SDCD_CMD_DES;
            else if (!s_act_n)
               nxt_cmd = `SDCD_CMD_ACT;
            else begin
               case ({s_ras, s_cas, s_we})
                  3'b000: nxt_cmd = `SDCD_CMD_MRS;
                  3'b001: nxt_cmd = `SDCD_CMD_REF;
                  3'b010: nxt_cmd = s_addr[`SDCD_A_AP] ? `SDCD_CMD_PREA : `SDCD_CMD_PRE;
                  3'b011: nxt_cmd = `SDCD_CMD_RFU;
                  3'b100: nxt_cmd = `SDCD_CMD_WR;
                  3'b101: nxt_cmd = `SDCD_CMD_RD;
                  3'b110: nxt_cmd = s_addr[`SDCD_A_AP] ? `SDCD_CMD_ZQCL : `SDCD_CMD_ZQCS;
                  3'b111: nxt_cmd = `SDCD_CMD_NOP;
                  default: nxt_cmd = `SDCD_CMD_ILL;
               endcase
            end
         end
         2'b10: begin
            if (s_cs_n)
               nxt_cmd = `SDCD_CMD_PDE;
            else if (s_act_n && {s_ras, s_cas, s_we} == 3'b001)
               nxt_cmd = `SDCD_CMD_SRE;
         end
         2'b01: begin
            if (s_cs_n)
               nxt_cmd = (mode_ff == ST_SR) ? `SDCD_CMD_SRX : `SDCD_CMD_PDX;
         end
         default: nxt_cmd = `SDCD_CMD_DES;               // cke held low: nothing new
      endcase
   end

   // ----------------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------------
   wire rw_cmd   = is_rw(nxt_cmd);
   wire nxt_chop = chop_sel(bl_mode_ff, s_addr[`SDCD_A_BC]);

   // command side: cke history, code and its valid flag
   always @(posedge mclk) begin
      if (!rst_n) begin
         cke_prev_ff <= 1'b0;
         cmd_ff      <= `SDCD_CMD_DES;
         cmd_vld_ff  <= 1'b0;
      end else if (clk_en) begin
         cke_prev_ff <= s_cke;
         cmd_ff      <= nxt_cmd;
         cmd_vld_ff  <= (nxt_cmd != `SDCD_CMD_DES);
      end
   end

   // field side: captured with every code so fields line up with cmd_ff
   always @(posedge mclk) begin
      if (!rst_n) begin
         bg_out_ff         <= {BG_W{1'b0}};
         ba_out_ff         <= {BA_W{1'b0}};
         addr_out_ff       <= {ADDR_W{1'b0}};
         auto_pre_ff       <= 1'b0;
         four_beat_chop_ff <= 1'b0;
      end else if (clk_en) begin
         bg_out_ff         <= s_bg;
         ba_out_ff         <= s_ba;
         addr_out_ff       <= nxt_addr;
         auto_pre_ff       <= rw_cmd & s_addr[`SDCD_A_AP];
         four_beat_chop_ff <= rw_cmd & nxt_chop;
      end
   end

   // ----------------------------------------------------------------------
   // burst length setting and burst tracker
   // ----------------------------------------------------------------------
   always @(posedge mclk) begin
      if (!rst_n) begin
         bl_mode_ff <= `SDCD_BL_FIX8;
      end else if (clk_en && mr0_write(nxt_cmd, s_bg[0], s_ba) && !burst_busy_ff) begin
         bl_mode_ff <= s_addr[`SDCD_MR0_BL_LO+1:`SDCD_MR0_BL_LO];
      end
   end

   // a new read or write is only accepted once the running burst is done
   always @(posedge mclk) begin
      if (!rst_n) begin
         beat_cnt_ff   <= 4'h0;
         burst_busy_ff <= 1'b0;
      end else if (clk_en) begin
         if (beat_cnt_ff > 4'h1) begin
            beat_cnt_ff   <= beat_cnt_ff - 4'h1;
            burst_busy_ff <= 1'b1;
         end else if (rw_cmd) begin
            beat_cnt_ff   <= burst_cycles(nxt_chop);
            burst_busy_ff <= 1'b1;
         end else begin
            beat_cnt_ff   <= 4'h0;
            burst_busy_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // power state: idle, self refresh, power-down
   // ----------------------------------------------------------------------
   always @(posedge mclk) begin
      if (!rst_n) begin
         mode_ff <= ST_IDLE;
      end else if (clk_en) begin
         case (mode_ff)
            ST_IDLE: begin
               if (nxt_cmd == `SDCD_CMD_SRE)
                  mode_ff <= ST_SR;
               else if (nxt_cmd == `SDCD_CMD_PDE)
                  mode_ff <= ST_PD;
            end
            ST_SR: begin
               if (nxt_cmd == `SDCD_CMD_SRX)
                  mode_ff <= ST_IDLE;
            end
            ST_PD: begin
               if (nxt_cmd == `SDCD_CMD_PDX)
                  mode_ff <= ST_IDLE;
            end
            default: mode_ff <= ST_IDLE;
         endcase
      end
   end

   // flags follow the entry code at once, not a cycle after the state
   always @(posedge mclk) begin
      if (!rst_n) begin
         refresh_ok_ff <= 1'b1;
         odt_en_ff     <= 1'b0;
      end else if (clk_en) begin
         refresh_ok_ff <= (mode_ff != ST_PD) && (nxt_cmd != `SDCD_CMD_PDE);
         odt_en_ff     <= s_odt && (mode_ff != ST_SR)
                          && (nxt_cmd != `SDCD_CMD_SRE);
      end
   end

endmodule // sdcd_decoder
`default_nettype wire

/* File: pkg/sdcd_defs.vh */
/*
 constants for the command decoder: command codes, field widths, burst figures.
 assumes inclusion by bare name from design files.
*/
`ifndef SDCD_DEFS_VH
`define SDCD_DEFS_VH

// ----------------------------------------------------------------------
// command codes (one-hot, 17 bits)
// ----------------------------------------------------------------------
`define SDCD_CMD_W      17
`define SDCD_CMD_DES    17'h00001
`define SDCD_CMD_MRS    17'h00002
`define SDCD_CMD_REF    17'h00004
`define SDCD_CMD_SRE    17'h00008
`define SDCD_CMD_SRX    17'h00010
`define SDCD_CMD_PRE    17'h00020
`define SDCD_CMD_PREA   17'h00040
`define SDCD_CMD_RFU    17'h00080
`define SDCD_CMD_ACT    17'h00100
`define SDCD_CMD_WR     17'h00200
`define SDCD_CMD_RD     17'h00400
`define SDCD_CMD_NOP    17'h00800
`define SDCD_CMD_PDE    17'h01000
`define SDCD_CMD_PDX    17'h02000
`define SDCD_CMD_ZQCL   17'h04000
`define SDCD_CMD_ZQCS   17'h08000
`define SDCD_CMD_ILL    17'h10000

// ----------------------------------------------------------------------
// field positions and figures
// ----------------------------------------------------------------------
`define SDCD_BG_W       2
`define SDCD_BA_W       2
`define SDCD_ADDR_W     18
`define SDCD_A_AP       10
`define SDCD_A_BC       12
`define SDCD_MR0_SEL    3'h0
`define SDCD_MR0_BL_LO  0
`define SDCD_BL_FIX8    2'h0
`define SDCD_BL_PERCMD  2'h1
`define SDCD_BL_FIX4    2'h2
`define SDCD_BEATS8     4'h4
`define SDCD_BEATS4     4'h2
`define SDCD_MODE_W     3
`define SDCD_MODE_IDLE  3'h1
`define SDCD_MODE_SR    3'h2
`define SDCD_MODE_PD    3'h4

`endif

/* File: tb/sdcd_ctrl_model.sv */
/* memory controller model driving the decoder pins.
 assumes the bench calls its tasks and drives reset itself. */
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctrl_model (
   input  wire logic        mclk,
   output var  logic        cke,
   output var  logic        cs_n,
   output var  logic        act_n,
   output var  logic        ras_n_a16,
   output var  logic        cas_n_a15,
   output var  logic        we_n_a14,
   output var  logic [1:0]  bg,
   output var  logic [1:0]  ba,
   output var  logic [17:0] addr,
   output var  logic        odt
);
   initial begin
      {cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} = 6'h3f;
      {bg, ba, addr, odt} = 23'h000000;
   end
   // ----------------------------------------
   // one command, then deselect cycles
   // ----------------------------------------
   task send(input logic [4:0] p, input logic k, input logic [3:0] gb, input logic [17:0] a);
      begin
         @(posedge mclk);
         {cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} <= p;
         cke <= k;
         {bg, ba} <= gb;
         addr <= a;
      end
   endtask
   task idle(input logic k);
      begin
         @(posedge mclk);
         cs_n <= 1'b1;
         cke <= k;
         // ignored pins keep moving
         {act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr} <=
            ~{act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr};
         odt <= ~odt;
      end
   endtask
endmodule // sdcd_ctrl_model
`default_nettype wire

/* File: tb/sdcd_decoder_assertions.sv */
/* assertions on the command decoder ports.
 assumes clk_en held high and the defs header on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_defs.vh"
module sdcd_chk (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic        act_n,
   input wire logic        ras_n_a16,
   input wire logic        cas_n_a15,
   input wire logic        we_n_a14,
   input wire logic [1:0]  bg,
   input wire logic [17:0] addr,
   input wire logic [16:0] cmd_ff,
   input wire logic        cmd_vld_ff,
   input wire logic [1:0]  bg_out_ff,
   input wire logic [17:0] addr_out_ff,
   input wire logic        auto_pre_ff,
   input wire logic        burst_busy_ff,
   input wire logic        odt_en_ff,
   input wire logic        refresh_ok_ff,
   input wire logic [2:0]  mode_ff
);
   // ----------------------------------------
   // decode checks, three cycles behind pins
   // ----------------------------------------
   reg [2:0] up_ff;
   always @(posedge mclk) begin
      if (!rst_n) up_ff <= 3'h0;
      else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence taken;
      up_ff == 3'h7 && $past(cke, 3) && $past(cke, 4) && !$past(cs_n, 3);
   endsequence
   one_hot_a: assert property ($onehot(cmd_ff))
      else $error("command not one-hot");
   valid_flag_a: assert property (cmd_vld_ff == (cmd_ff != `SDCD_CMD_DES))
      else $error("valid flag wrong");
   deselect_cmd_a: assert property (
      up_ff == 3'h7 && $past(cke, 3) && $past(cke, 4) && $past(cs_n, 3)
      |-> cmd_ff == `SDCD_CMD_DES) else $error("deselect not decoded");
   act_row_a: assert property (taken ##0 !$past(act_n, 3)
      |-> cmd_ff == `SDCD_CMD_ACT && addr_out_ff[16] == $past(ras_n_a16, 3)
      && addr_out_ff[14] == $past(we_n_a14, 3)) else $error("activate row wrong");
   mode_set_a: assert property (taken ##0 $past(act_n, 3) && !$past(ras_n_a16, 3)
      && !$past(cas_n_a15, 3) && !$past(we_n_a14, 3)
      |-> cmd_ff == `SDCD_CMD_MRS && bg_out_ff == $past(bg, 3)) else $error("mode set wrong");
   read_write_a: assert property (taken ##0 $past(act_n, 3) && $past(ras_n_a16, 3)
      && !$past(cas_n_a15, 3) |-> auto_pre_ff == $past(addr[10], 3) && cmd_ff ==
      ($past(we_n_a14, 3) ? `SDCD_CMD_RD : `SDCD_CMD_WR)) else $error("read/write wrong");
   odt_off_a: assert property (mode_ff == `SDCD_MODE_SR |-> !odt_en_ff)
      else $error("termination on in self refresh");
   pd_norefresh_a: assert property (mode_ff == `SDCD_MODE_PD |-> !refresh_ok_ff)
      else $error("refresh allowed in power-down");
   burst_hold_a: assert property ($rose(burst_busy_ff) |-> burst_busy_ff[*2])
      else $error("burst cut short");
endmodule // sdcd_chk
bind sdcd_decoder sdcd_chk chk_u (.mclk, .rst_n, .cke, .cs_n, .act_n, .ras_n_a16,
   .cas_n_a15, .we_n_a14, .bg, .addr, .cmd_ff, .cmd_vld_ff, .bg_out_ff, .addr_out_ff,
   .auto_pre_ff, .burst_busy_ff, .odt_en_ff, .refresh_ok_ff, .mode_ff);
`default_nettype wire

/* File: tb/tb_top.sv */
/* bench for the command decoder: codes, row capture, burst length, cke modes.
 assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_defs.vh"
module tb_top;
   logic        mclk, rst_n;
   wire         cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14, odt, cmd_vld_ff;
   wire         auto_pre_ff, four_beat_chop_ff, burst_busy_ff, odt_en_ff, refresh_ok_ff;
   wire [1:0]   bg, ba, bg_out_ff, ba_out_ff;
   wire [17:0]  addr, addr_out_ff;
   wire [16:0]  cmd_ff;
   wire [2:0]   mode_ff;
   int          n_fail = 0;
   int          samples_checked = 0;
   sdcd_ctrl_model ctrl_u (.mclk, .cke, .cs_n, .act_n, .ras_n_a16, .cas_n_a15, .we_n_a14,
      .bg, .ba, .addr, .odt);
   sdcd_decoder dut_u (.mclk, .rst_n, .clk_en(1'b1), .cke, .cs_n, .act_n, .ras_n_a16,
      .cas_n_a15, .we_n_a14, .bg, .ba, .addr, .odt, .cmd_ff, .cmd_vld_ff, .bg_out_ff,
      .ba_out_ff, .addr_out_ff, .auto_pre_ff, .four_beat_chop_ff, .burst_busy_ff,
      .odt_en_ff, .refresh_ok_ff, .mode_ff);
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         samples_checked++;
         if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task run(input logic [4:0] p, input logic k, input logic [3:0] gb, input logic [17:0] a);
      begin
         ctrl_u.send(p, k, gb, a);
         repeat (3) ctrl_u.idle(k);
         #1;
      end
   endtask
   task step(input logic k);
      begin
         ctrl_u.idle(k);
         #1;
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d failures %0d", samples_checked, n_fail);
         if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_codes;
      logic [4:0]  pin_tab [0:8];
      logic [16:0] exp_tab [0:8];
      logic [8:0]  a10_tab;
      begin
         pin_tab = '{5'h08, 5'h09, 5'h0a, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0e};
         exp_tab = '{`SDCD_CMD_MRS, `SDCD_CMD_REF, `SDCD_CMD_PRE, `SDCD_CMD_PREA,
            `SDCD_CMD_RFU, `SDCD_CMD_WR, `SDCD_CMD_RD, `SDCD_CMD_ZQCL, `SDCD_CMD_ZQCS};
         a10_tab = 9'h0a8;
         chk(cmd_ff, `SDCD_CMD_DES);
         for (int i = 0; i < 9; i++) begin
            run(pin_tab[i], 1'b1, 4'h0, {7'h00, a10_tab[i], 10'h000});
            chk(cmd_ff, exp_tab[i]);
            chk(cmd_vld_ff, 1'b1);
         end
         $display("test codes done");
      end
   endtask
   task t_act;
      begin
         run(5'h05, 1'b1, 4'hb, 18'h3c123);
         chk(cmd_ff, `SDCD_CMD_ACT);
         chk(addr_out_ff, 18'h34123);
         chk({bg_out_ff, ba_out_ff}, 4'hb);
         $display("test activate done");
      end
   endtask
   task t_burst;
      begin
         run(5'h08, 1'b1, 4'h0, 18'h00001);
         run(5'h0d, 1'b1, 4'h0, 18'h00000);
         chk({four_beat_chop_ff, burst_busy_ff}, 2'h3);
         run(5'h0c, 1'b1, 4'h0, 18'h01400);
         chk({four_beat_chop_ff, auto_pre_ff}, 2'h1);
         step(1'b1);
         chk(burst_busy_ff, 1'b1);
         run(5'h08, 1'b1, 4'h0, 18'h00002);
         run(5'h0d, 1'b1, 4'h0, 18'h01000);
         chk(four_beat_chop_ff, 1'b1);
         run(5'h08, 1'b1, 4'h0, 18'h00000);
         run(5'h0d, 1'b1, 4'h0, 18'h00000);
         chk(four_beat_chop_ff, 1'b0);
         $display("test burst done");
      end
   endtask
   task t_power;
      begin
         run(5'h1f, 1'b0, 4'h0, 18'h00000);
         chk(cmd_ff, `SDCD_CMD_PDE);
         step(1'b0);
         chk({mode_ff, refresh_ok_ff}, {`SDCD_MODE_PD, 1'b0});
         run(5'h1f, 1'b1, 4'h0, 18'h00000);
         chk(cmd_ff, `SDCD_CMD_PDX);
         run(5'h09, 1'b0, 4'h0, 18'h00000);
         chk(cmd_ff, `SDCD_CMD_SRE);
         step(1'b0);
         chk({mode_ff, odt_en_ff}, {`SDCD_MODE_SR, 1'b0});
         run(5'h1f, 1'b1, 4'h0, 18'h00000);
         chk(cmd_ff, `SDCD_CMD_SRX);
         step(1'b1);
         chk(mode_ff, `SDCD_MODE_IDLE);
         chk(refresh_ok_ff, 1'b1);
         $display("test power done");
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      rst_n = 1'b0;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (6) ctrl_u.idle(1'b1);
      #1;
      t_codes;
      t_act;
      t_burst;
      t_power;
      stop_test;
   end
   initial begin
      #4000;
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      stop_test;
   end
endmodule // tb_top
`default_nettype wire
